// ==== rtl/sram_wr_host.sv ====
// host-side write controller for a battery-backed byte-wide static ram
// What this block does
// - host holds the address stable for the whole write cycle.
// - host keeps strobe/select inactive 10 ns before another cycle.
// - data valid 25 ns before the ending edge, held 5 ns after.
// - with two-wire control the host avoids bus contention with the ram.
// - host keeps the selects inactive while supply power returns.
`timescale 1ns/1ps
`include "sram_host_regs.svh"
`default_nettype none
module sram_wr_host #(
  parameter int unsigned RESTART_CYC = `CEIL_CYC(`RESTART_DELAY_NS)
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // user request
  input  wire logic                  req_valid,
  input  wire logic [`ADDR_W-1:0]    req_addr,
  input  wire logic [`DATA_W-1:0]    req_data,
  output logic                       req_ready,
  output logic                       req_done,
  output logic                       req_reject,
  // power status from the supply monitor and the ram
  input  wire logic                  pwr_fail,
  input  wire logic                  pwr_int_n,
  // ram pins
  output logic [`ADDR_W-1:0]         addr,
  output logic                       write_n,
  output logic                       select_one_n,
  output logic                       select_two,
  output logic                       out_en_n,
  output logic [`DATA_W-1:0]         dq_out,
  output logic                       dq_oe,
  input  wire logic [`DATA_W-1:0]    dq_in
);
  logic                   dq_unused;
  pwr_gate_if             pg ();
  sram_host_pkg::wr_state_t st_ff;
  sram_host_pkg::wr_state_t nxt_st;
  logic [7:0]             cnt_ff;
  logic [7:0]             nxt_cnt;
  logic [`ADDR_W-1:0]     addr_ff;
  logic [`ADDR_W-1:0]     nxt_addr;
  logic [`DATA_W-1:0]     data_ff;
  logic [`DATA_W-1:0]     nxt_data;
  logic                   wr_n_ff;
  logic                   nxt_wr_n;
  logic                   sel_ff;
  logic                   nxt_sel;
  logic                   oe_ff;
  logic                   nxt_oe;
  logic                   rdy_ff;
  logic                   nxt_rdy;
  logic                   done_ff;
  logic                   nxt_done;
  logic                   rej_ff;
  logic                   nxt_rej;

  // reads are not issued by this block; read path is left for another controller
  assign dq_unused = ^dq_in;

  // power gate holds off accesses around a supply dip
  pwr_gate #(
    .RESTART_CYC (RESTART_CYC)
  ) u_gate (
    .mclk      (mclk),
    .rst       (rst),
    .pwr_fail  (pwr_fail),
    .pwr_int_n (pwr_int_n),
    .pg        (pg)
  );

  // cycle count to the next phase, rounded up from the timing figures
  function automatic logic [7:0] cyc(input int unsigned n);
    cyc = 8'(n);
  endfunction : cyc

  // write sequencer: address/select first, then strobe, then hold and recovery
  always_comb
  begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_wr_n = wr_n_ff;
    nxt_sel  = sel_ff;
    nxt_oe   = oe_ff;
    nxt_rdy  = 1'b0;
    nxt_done = 1'b0;
    nxt_rej  = 1'b0;
    if (cnt_ff != 8'h00)
      nxt_cnt = cnt_ff - 8'h01;
    unique case (st_ff)
      sram_host_pkg::ST_IDLE:
      begin
        nxt_sel = 1'b0;
        nxt_rdy = 1'b1;
        if (req_valid && rdy_ff)
        begin
          nxt_rdy = 1'b0;
          if (!pg.allow || pwr_fail)
            nxt_rej = 1'b1;
          else
          begin
            nxt_addr = req_addr;
            nxt_data = req_data;
            nxt_sel  = 1'b1;
            nxt_st   = sram_host_pkg::ST_SETUP;
            nxt_cnt  = cyc(`OUT_HIZ_CYC);
          end
        end
      end
      sram_host_pkg::ST_SETUP:
      begin
        nxt_wr_n = 1'b0;
        if (cnt_ff == 8'h00)
        begin
          nxt_oe  = 1'b1;
          nxt_st  = sram_host_pkg::ST_STROBE;
          nxt_cnt = cyc(`WR_PULSE_CYC > `DATA_SETUP_CYC ? `WR_PULSE_CYC : `DATA_SETUP_CYC);
        end
      end
      sram_host_pkg::ST_STROBE:
      begin
        if (pwr_fail)
        begin
          nxt_wr_n = 1'b1;
          nxt_sel  = 1'b0;
          nxt_oe   = 1'b0;
          nxt_rej  = 1'b1;
          nxt_st   = sram_host_pkg::ST_RECOV;
          nxt_cnt  = cyc(`WR_RECOVERY_CYC);
        end
        else if (cnt_ff == 8'h00)
        begin
          nxt_wr_n = 1'b1;
          nxt_st   = sram_host_pkg::ST_HOLD;
          nxt_cnt  = cyc(`DATA_HOLD_CYC);
        end
      end
      sram_host_pkg::ST_HOLD:
      begin
        if (cnt_ff == 8'h00)
        begin
          nxt_oe   = 1'b0;
          nxt_sel  = 1'b0;
          nxt_done = 1'b1;
          nxt_st   = sram_host_pkg::ST_RECOV;
          nxt_cnt  = cyc(`WR_RECOVERY_CYC);
        end
      end
      sram_host_pkg::ST_RECOV:
      begin
        if (cnt_ff == 8'h00)
          nxt_st = sram_host_pkg::ST_IDLE;
      end
      default:
      begin
        nxt_st   = sram_host_pkg::ST_IDLE;
        nxt_wr_n = 1'b1;
        nxt_sel  = 1'b0;
        nxt_oe   = 1'b0;
      end
    endcase
  end

  // all pins but out_en_n (tied high) come from flops; strobes start inactive
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_ff   <= sram_host_pkg::ST_IDLE;
      cnt_ff  <= 8'h00;
      addr_ff <= {`ADDR_W{1'b0}};
      data_ff <= {`DATA_W{1'b0}};
      wr_n_ff <= 1'b1;
      sel_ff  <= 1'b0;
      oe_ff   <= 1'b0;
      rdy_ff  <= 1'b0;
      done_ff <= 1'b0;
      rej_ff  <= 1'b0;
    end
    else
    begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      wr_n_ff <= nxt_wr_n;
      sel_ff  <= nxt_sel;
      oe_ff   <= nxt_oe;
      rdy_ff  <= nxt_rdy;
      done_ff <= nxt_done;
      rej_ff  <= nxt_rej;
    end
  end

  // both selects move together so either polarity of part works
  assign addr         = addr_ff;
  assign write_n      = wr_n_ff;
  assign select_one_n = ~sel_ff;
  assign select_two   = sel_ff;
  assign out_en_n     = 1'b1;
  assign dq_out       = data_ff;
  assign dq_oe        = oe_ff;
  assign req_ready    = rdy_ff;
  assign req_done     = done_ff;
  assign req_reject   = rej_ff;
endmodule : sram_wr_host
`default_nettype wire

// ==== pkg/sram_host_regs.svh ====
// timing constants and widths for the battery-backed sram write controller
`ifndef SRAM_HOST_REGS_SVH
`define SRAM_HOST_REGS_SVH
`define CLK_PERIOD_NS      10
`define ADDR_W             13
`define DATA_W             8
`define WR_PULSE_NS        35
`define DATA_SETUP_NS      25
`define DATA_HOLD_NS       5
`define WR_RECOVERY_NS     10
`define OUT_HIZ_NS         30
`define RESTART_DELAY_NS   1000000
`define CEIL_CYC(ns)       (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WR_PULSE_CYC       `CEIL_CYC(`WR_PULSE_NS)
`define DATA_SETUP_CYC     `CEIL_CYC(`DATA_SETUP_NS)
`define DATA_HOLD_CYC      `CEIL_CYC(`DATA_HOLD_NS)
`define WR_RECOVERY_CYC    `CEIL_CYC(`WR_RECOVERY_NS)
`define OUT_HIZ_CYC        `CEIL_CYC(`OUT_HIZ_NS)
`endif

// ==== pkg/sram_host_pkg.sv ====
// types shared by the sram write controller modules
package sram_host_pkg;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_SETUP  = 5'h02,
    ST_STROBE = 5'h04,
    ST_HOLD   = 5'h08,
    ST_RECOV  = 5'h10
  } wr_state_t;
endpackage : sram_host_pkg

// ==== pkg/pwr_gate_if.sv ====
// signals between the power gate and the write sequencer
`timescale 1ns/1ps
`default_nettype none
interface pwr_gate_if;
  logic allow;
  modport gate (output allow);
  modport seq  (input allow);
endinterface : pwr_gate_if
`default_nettype wire

// ==== rtl/pwr_gate.sv ====
// power-fail gate: blocks access during power fail and for the restart delay after it
`timescale 1ns/1ps
`include "sram_host_regs.svh"
`default_nettype none
module pwr_gate #(
  parameter int unsigned RESTART_CYC = `CEIL_CYC(`RESTART_DELAY_NS)
) (
  // clock and reset
  input  wire logic  mclk,
  input  wire logic  rst,
  // power status
  input  wire logic  pwr_fail,
  input  wire logic  pwr_int_n,
  // sequencer side
  pwr_gate_if.gate   pg
);
  logic [19:0] cnt_ff;
  logic [19:0] nxt_cnt;
  logic        allow_ff;
  logic        nxt_allow;

  // a fresh fail restarts the count; the interrupt also stops new cycles early
  always_comb
  begin
    nxt_cnt   = cnt_ff;
    nxt_allow = 1'b0;
    if (pwr_fail || !pwr_int_n)
      nxt_cnt = 20'(RESTART_CYC);
    else if (cnt_ff != 20'h00000)
      nxt_cnt = cnt_ff - 20'h00001;
    else
      nxt_allow = 1'b1;
  end

  // start blocked: power may be rising at reset
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff   <= 20'(RESTART_CYC);
      allow_ff <= 1'b0;
    end
    else
    begin
      cnt_ff   <= nxt_cnt;
      allow_ff <= nxt_allow;
    end
  end

  assign pg.allow = allow_ff;
endmodule : pwr_gate
`default_nettype wire

// ==== tb/sram_wr_monitor.sv ====
// checker on the sram write controller pins
`timescale 1ns/1ps
`include "sram_host_regs.svh"
`default_nettype none
module sram_wr_monitor (
  // clock and power
  input wire logic               mclk,
  input wire logic               rst,
  input wire logic               pwr_fail,
  // ram pins
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic               write_n,
  input wire logic               select_one_n,
  input wire logic [`DATA_W-1:0] dq_out,
  input wire logic               dq_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // address frozen while selected
  addr_hold_a: assert property (!select_one_n |=> select_one_n || $stable(addr))
    else $error("addr moved");
  write_recov_a: assert property ($rose(select_one_n) |=> select_one_n && write_n)
    else $error("no recovery");
  // data valid 2 cycles before the strobe ends, 1 after
  data_setup_a: assert property ($rose(write_n) && !pwr_fail |-> $past(dq_oe, 2) && $stable(dq_out))
    else $error("short setup");
  data_hold_a: assert property ($rose(write_n) && !pwr_fail |=> dq_oe && $stable(dq_out))
    else $error("short hold");
  // drive only once the ram outputs have floated
  bus_drive_a: assert property ($rose(dq_oe) |-> !write_n && !$past(write_n, 2))
    else $error("contention");
  pf_abort_a: assert property (pwr_fail && !write_n |-> ##[1:3] write_n)
    else $error("write not stopped");
  // no fresh select while the supply is failing
  no_select_pf_a: assert property (pwr_fail && select_one_n |=> select_one_n)
    else $error("select in power fail");
  cover property ($rose(write_n) && !pwr_fail);
  cover property (pwr_fail && !write_n);
  cover property ($rose(dq_oe));
endmodule : sram_wr_monitor
bind sram_wr_host sram_wr_monitor i_mon (.mclk(mclk), .rst(rst), .pwr_fail(pwr_fail), .addr(addr),
  .write_n(write_n), .select_one_n(select_one_n), .dq_out(dq_out), .dq_oe(dq_oe));
`default_nettype wire

// ==== tb/sram_model.sv ====
// behavioural far-side ram
`timescale 1ns/1ps
`include "sram_host_regs.svh"
`default_nettype none
module sram_model #(
  parameter int RESTART_NS  = 1000000,  // restart delay after the supply returns
  parameter int DESELECT_NS = 10000     // interrupt to automatic deselect
) (
  // ram control
  input  wire logic [`ADDR_W-1:0] addr,
  input  wire logic               write_n,
  input  wire logic               select_one_n,
  input  wire logic               select_two,
  input  wire logic               pwr_fail,
  // data and interrupt
  input  wire logic [`DATA_W-1:0] dq_out,
  input  wire logic               dq_oe,
  output logic      [`DATA_W-1:0] dq_in,
  output logic                    pwr_int_n
);
  logic [`DATA_W-1:0] mem [2**`ADDR_W];
  logic [`DATA_W-1:0] last_q;
  logic               restarting = 1'b0;
  logic               desel = 1'b0;
  // later activation opens the write, earlier release closes it
  wire act = !write_n && !select_one_n && select_two;
  // our outputs float in a write; a released bus shows no stale byte
  assign dq_in = dq_oe ? dq_out : ~last_q;
  assign pwr_int_n = !pwr_fail;
  always @(dq_out or dq_oe) if (dq_oe) last_q = dq_out;
  // deselected in the fail window; a drop mid-write spoils this byte only
  always @(negedge act) if (!pwr_fail && !desel && !restarting) mem[addr] = dq_in;
  // writes stay ignored for the restart delay once the supply is back
  always @(negedge pwr_fail)
  begin
    restarting = 1'b1;
    #(RESTART_NS) restarting = 1'b0;
  end
  // the internal timer deselects only if the interrupt is still low
  always @(negedge pwr_int_n)
  begin
    #(DESELECT_NS) desel = !pwr_int_n;
    wait (pwr_int_n) desel = 1'b0;
  end
  always @(posedge pwr_fail) if (act) mem[addr] = ~dq_in;
endmodule : sram_model
`default_nettype wire

// ==== tb/sram_wr_host_test.sv ====
// self-checking bench for the sram write controller
`timescale 1ns/1ps
`include "sram_host_regs.svh"
`default_nettype none
module sram_wr_host_test;
  typedef struct packed {logic [`ADDR_W-1:0] a; logic [`DATA_W-1:0] d;} row_t;
  logic mclk, rst, req_valid, req_ready, req_done, req_reject, pwr_fail, pwr_int_n;
  logic write_n, select_one_n, select_two, out_en_n, dq_oe;
  logic [`ADDR_W-1:0] req_addr, addr;
  logic [`DATA_W-1:0] req_data, dq_out, dq_in;
  logic [1:0] res;
  int error_cnt, n_compared, lat;
  row_t rows [3] = '{21'h00005A, 21'h1FFFA5, 21'h0ABC00};
  sram_wr_host #(.RESTART_CYC(20)) i_sram_wr_host (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready), .req_done(req_done),
    .req_reject(req_reject), .pwr_fail(pwr_fail), .pwr_int_n(pwr_int_n), .addr(addr),
    .write_n(write_n), .select_one_n(select_one_n), .select_two(select_two), .out_en_n(out_en_n),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  sram_model #(.RESTART_NS(200)) i_sram_model (.addr(addr), .write_n(write_n), .select_one_n(select_one_n),
    .select_two(select_two), .pwr_fail(pwr_fail), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in), .pwr_int_n(pwr_int_n));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %0h vs %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("%0d compared, %0d mismatches", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // one request; res 1 done, 2 refused; lat counts edges from take
  task automatic wr(input row_t r);
    int t;
    t = -1;
    res = 2'h0;
    @(posedge mclk);
    {req_addr, req_data} <= r;
    req_valid <= 1'b1;
    for (int i = 0; i < 60 && res == 2'h0; i++)
    begin
      @(posedge mclk);
      lat = i - t;
      if (req_reject) res = 2'h2;
      else if (t >= 0 && req_done) res = 2'h1;
      if (t < 0 && req_ready)
      begin
        t = i;
        req_valid <= 1'b0;
      end
    end
    req_valid <= 1'b0;
  endtask : wr
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // watchdog well past the whole run
  initial
  begin
    repeat (2000) @(posedge mclk);
    error_cnt++;
    final_report();
  end
  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_addr = '0;
    req_data = '0;
    pwr_fail = 1'b0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    chk({write_n, select_one_n, dq_oe, out_en_n}, 4'hD);
    // straight after reset the gate still waits out the restart delay
    wr(rows[0]);
    chk(res, 2'h2);
    repeat (25) @(posedge mclk);
    $display("startup done");
    foreach (rows[k])
    begin
      wr(rows[k]);
      chk({res, lat > 10 && lat < 13}, 3'h3);
      chk(i_sram_model.mem[rows[k].a], rows[k].d);
      $display("row done");
    end
    // refused in the fail window and in the restart delay
    pwr_fail <= 1'b1;
    wr({rows[0].a, 8'h3C});
    chk(res, 2'h2);
    pwr_fail <= 1'b0;
    wr({rows[0].a, 8'h3C});
    chk(res, 2'h2);
    chk(i_sram_model.mem[rows[0].a], rows[0].d);
    $display("refusal done");
    // supply drops in mid-strobe
    repeat (30) @(posedge mclk);
    fork
      wr({rows[1].a, 8'h77});
      begin
        @(negedge write_n);
        repeat (2) @(posedge mclk);
        pwr_fail <= 1'b1;
      end
    join
    chk(res, 2'h2);
    chk(i_sram_model.mem[rows[2].a], rows[2].d);
    pwr_fail <= 1'b0;
    repeat (30) @(posedge mclk);
    wr({rows[1].a, 8'h77});
    chk(i_sram_model.mem[rows[1].a], 8'h77);
    $display("power drop done");
    final_report();
  end
endmodule : sram_wr_host_test
`default_nettype wire
